// ---- logic/cec_pkg.sv ----
/*
 * Package for the comparator event control block: register indices,
 * field positions, reset values, encodings and the carrier structs.
 * Assumes a 32-bit Avalon-MM slave with byte addressing of 16-bit registers.
 */
package cec_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [3:0] CEC_IDX_STATUS = 4'h0;
    localparam logic [3:0] CEC_IDX_CTRL1 = 4'h1;
    localparam logic [3:0] CEC_IDX_CTRL2 = 4'h2;
    localparam logic [3:0] CEC_IDX_CTRL3 = 4'h3;
    localparam logic [3:0] CEC_IDX_CTRL4 = 4'h4;
    localparam logic [3:0] CEC_IDX_BLANK1 = 4'h5;
    localparam logic [3:0] CEC_IDX_BLANK4 = 4'h8;
    localparam logic [3:0] CEC_IDX_LAST = 4'h8;
    // Control register field positions
    localparam int CEC_B_ENABLE = 15;
    localparam int CEC_B_PIN_OE = 14;
    localparam int CEC_B_INVERT = 13;
    localparam int CEC_B_AMP = 10;
    localparam int CEC_B_EVENT = 9;
    localparam int CEC_B_RESULT = 8;
    localparam int CEC_B_EDGE_LO = 6;
    localparam int CEC_B_REF = 4;
    localparam int CEC_B_NEG_LO = 0;
    // Status register field positions
    localparam int CEC_B_IDLE_HALT = 15;
    localparam int CEC_B_EVT_MIRROR = 8;
    localparam int CEC_B_RES_MIRROR = 0;
    // Writable masks: unimplemented bits ignore writes and read zero
    localparam logic [15:0] CEC_CTRL13_WMASK = 16'hE6D3;
    localparam logic [15:0] CEC_CTRL4_WMASK = 16'hE2D3;
    localparam logic [15:0] CEC_BLANK_WMASK = 16'h0FFF;
    localparam logic [15:0] CEC_RESET_VALUE = 16'h0000;
    // Event edge select encodings
    localparam logic [1:0] CEC_EDGE_OFF = 2'h0;
    localparam logic [1:0] CEC_EDGE_RISE = 2'h1;
    localparam logic [1:0] CEC_EDGE_FALL = 2'h2;
    localparam logic [1:0] CEC_EDGE_ANY = 2'h3;
    // Negative input select encodings
    localparam logic [1:0] CEC_NEG_FIRST = 2'h0;
    localparam logic [1:0] CEC_NEG_SECOND = 2'h1;
    // Blanking source encodings, highest legal PWM code and first non-PWM
    localparam logic [3:0] CEC_SRC_PWM_LAST = 4'h5;
    localparam logic [3:0] CEC_SRC_TRIG18 = 4'hC;
    localparam logic [3:0] CEC_SRC_TRIG19 = 4'hD;
    localparam logic [3:0] CEC_SRC_FAULT2 = 4'hE;
    localparam logic [3:0] CEC_SRC_FAULT4 = 4'hF;
    // Read answer latency of the slave in cycles
    localparam int CEC_READ_WAIT = 1;

    // Analog routing controls for one unit
    typedef struct packed {
        logic unit_enable;
        logic amplifier_mode_select;
        logic positive_input_ref_select;
        logic [1:0] neg_sel;
        logic neg_ground;
    } cec_route_t;

    // Sources feeding the blanking selectors
    typedef struct packed {
        logic fault_input_four;
        logic fault_input_two;
        logic trigger_gen_out_19;
        logic trigger_gen_out_18;
        logic pwm_gen3_high_out;
        logic pwm_gen3_low_out;
        logic pwm_gen2_high_out;
        logic pwm_gen2_low_out;
        logic pwm_gen1_high_out;
        logic pwm_gen1_low_out;
    } cec_blank_src_t;
endpackage : cec_pkg

// ---- logic/cec_top.sv ----
/*
 * Comparator event control: registers, polarity, pin enables, event latch,
 * input routing and blanking source selection for four comparator units.
 * Assumes raw analog comparator results are asynchronous and that an
 * Avalon-MM master addresses 32-bit words; the low 16 bits carry data.
 */
// Chosen here: the Avalon-MM register port and the register addresses.
// Operation
// - control top bit enables the unit
// - pin enable puts result on pin
// - invert bit flips result for all users
// - result bit reads polarity adjusted compare
// - units 1 to 3 mode bit selects amplifier
// - amplifier mode withholds pin and second negative
// - event flag latches, blocks further events
// - edge code 11 fires on any change
// - edge code 10 fires on adjusted fall
// - edge code 01 fires on adjusted rise
// - edge code 00 fires nothing
// - reference bit routes internal reference positive
// - units 1-3 negative select codes 00, 01
// - unit 4 negative select picks amplifier outputs
// - absent selected source connects input to ground
// - status low bits mirror each result
// - status event bits mirror each flag
// - mask C field selects blanking source
// - mask B field uses same encoding
// - mask A field uses same encoding
// - unimplemented bits ignore writes, read zero
// - idle halt bit stops units in idle
`timescale 1ns/1ns
module cec_top
    import cec_pkg::*;
#(
    parameter int UNITS = 4
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire logic idle_mode,
    input wire logic [UNITS-1:0] raw_result,
    input wire cec_blank_src_t blank_src,
    output logic [UNITS-1:0] compare_output_pin,
    output logic [UNITS-1:0] event_pulse,
    output cec_route_t [UNITS-1:0] route_ff,
    output logic [UNITS-1:0] unit_active,
    output logic [3*UNITS-1:0] blank_mask_ff
);
    // Elaboration check: the block serves exactly four units
    if (UNITS != 4) begin : g_bad_units
        $error("cec_top supports exactly four units");
    end

    logic [15:0] ctrl_ff [UNITS];        // Control registers
    logic [15:0] blank_sel_ff [UNITS];   // Blanking source selectors
    logic idle_halt_select_ff;            // Stop units in idle
    logic [UNITS-1:0] sync1_ff;          // Synchroniser stage one
    logic [UNITS-1:0] sync2_ff;          // Synchroniser stage two
    logic [UNITS-1:0] sync3_ff;          // Synchroniser stage three
    logic [UNITS-1:0] stable_ff;         // Accepted raw level
    logic [UNITS-1:0] adj_prev_ff;       // Previous adjusted result
    logic [UNITS-1:0] adj;               // Polarity adjusted result
    logic [UNITS-1:0] fire;              // Qualified edge this cycle
    logic [UNITS-1:0] running;           // Unit enabled and not halted
    logic rd_pend_ff;                    // Read answer under way
    logic [15:0] rd_word;                // Decoded read word
    logic [3:0] idx;                     // Word index of access
    logic wr_lo;                         // Write enabling both low byte lanes
    logic [15:0] status_word;            // Shared status image

    assign idx = avs_address[5:2];
    assign wr_lo = avs_write && (avs_byteenable[1:0] == 2'h3);

    // Unit runs when enabled and not halted by idle
    assign running = unit_active;

    // Status image from result and event bits
    always_comb
    begin
        status_word = CEC_RESET_VALUE;
        status_word[CEC_B_IDLE_HALT] = idle_halt_select_ff;
        for (int i = 0; i < UNITS; i++)
        begin
            status_word[CEC_B_RES_MIRROR + i] = ctrl_ff[i][CEC_B_RESULT];
            status_word[CEC_B_EVT_MIRROR + i] = ctrl_ff[i][CEC_B_EVENT];
        end
    end

    // Read multiplexer; unmapped words read zero
    always_comb
    begin
        rd_word = CEC_RESET_VALUE;
        if (idx == CEC_IDX_STATUS)
        begin
            rd_word = status_word;
        end
        else if (idx >= CEC_IDX_CTRL1 && idx <= CEC_IDX_CTRL4)
        begin
            rd_word = ctrl_ff[2'(idx - CEC_IDX_CTRL1)];
        end
        else if (idx >= CEC_IDX_BLANK1 && idx <= CEC_IDX_BLANK4)
        begin
            rd_word = blank_sel_ff[2'(idx - CEC_IDX_BLANK1)];
        end
    end

    // Bus answer: writes finish at once, reads hold one wait cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rd_pend_ff <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_response_err <= 1'b0;
        end
        else
        begin
            rd_pend_ff <= avs_read && !rd_pend_ff;
            if (avs_read && !rd_pend_ff)
            begin
                avs_readdata <= {16'h0000, rd_word};
                avs_response_err <= (idx > CEC_IDX_LAST);
            end
        end
    end

    // Waitrequest is low for writes and in the read answer cycle
    assign avs_waitrequest = avs_read && !rd_pend_ff;

    // Idle halt bit
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            idle_halt_select_ff <= 1'b0;
        end
        else if (wr_lo && idx == CEC_IDX_STATUS)
        begin
            idle_halt_select_ff <= avs_writedata[CEC_B_IDLE_HALT];
        end
    end

    // Three stage synchroniser and agreement filter
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            stable_ff <= '0;
        end
        else
        begin
            sync1_ff <= raw_result;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            // Accept a level only when stages two and three agree
            stable_ff <= (sync3_ff & ~(sync2_ff ^ sync3_ff))
                | (stable_ff & (sync2_ff ^ sync3_ff));
        end
    end

    genvar g;
    generate
        for (g = 0; g < UNITS; g++)
        begin : g_unit
            localparam bit HAS_AMP = (g < 3);
            localparam logic [15:0] WMASK = HAS_AMP ? CEC_CTRL13_WMASK : CEC_CTRL4_WMASK;
            logic sel_wr;
            logic bsel_wr;
            logic [1:0] edge_sel;
            logic [1:0] neg;
            logic amp;
            logic [3:0] src [3];
            logic [2:0] picked;

            assign sel_wr = wr_lo && idx == 4'(CEC_IDX_CTRL1 + g);
            assign bsel_wr = wr_lo && idx == 4'(CEC_IDX_BLANK1 + g);
            assign edge_sel = ctrl_ff[g][CEC_B_EDGE_LO +: 2];
            assign neg = ctrl_ff[g][CEC_B_NEG_LO +: 2];
            assign amp = HAS_AMP && ctrl_ff[g][CEC_B_AMP];

            // Invert bit applied to synchronised level
            assign adj[g] = stable_ff[g] ^ ctrl_ff[g][CEC_B_INVERT];

            // Edge qualification, blocked while flag is set
            always_comb
            begin
                fire[g] = 1'b0;
                if (running[g] && !ctrl_ff[g][CEC_B_EVENT])
                begin
                    case (edge_sel)
                        CEC_EDGE_ANY: fire[g] = adj[g] != adj_prev_ff[g];
                        CEC_EDGE_FALL: fire[g] = adj_prev_ff[g] && !adj[g];
                        CEC_EDGE_RISE: fire[g] = !adj_prev_ff[g] && adj[g];
                        default: fire[g] = 1'b0;
                    endcase
                end
            end

            // Control register: result tracks unit, event flag set beats clear
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    ctrl_ff[g] <= CEC_RESET_VALUE;
                    adj_prev_ff[g] <= 1'b0;
                end
                else
                begin
                    adj_prev_ff[g] <= adj[g];
                    if (sel_wr)
                    begin
                        ctrl_ff[g] <= (avs_writedata[15:0] & WMASK)
                            | (ctrl_ff[g] & ~WMASK);
                        // Software may only clear the flag by writing zero
                        ctrl_ff[g][CEC_B_EVENT] <= fire[g] || (ctrl_ff[g][CEC_B_EVENT]
                            && avs_writedata[CEC_B_EVENT]);
                    end
                    else if (fire[g])
                    begin
                        ctrl_ff[g][CEC_B_EVENT] <= 1'b1;
                    end
                    // Result is hardware owned, zero while unit stopped
                    ctrl_ff[g][CEC_B_RESULT] <= running[g] && adj[g];
                end
            end

            // Blanking selector register
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    blank_sel_ff[g] <= CEC_RESET_VALUE;
                end
                else if (bsel_wr)
                begin
                    blank_sel_ff[g] <= avs_writedata[15:0] & CEC_BLANK_WMASK;
                end
            end

            // Source decode shared by masks A, B and C; reserved gives zero
            assign src[0] = blank_sel_ff[g][3:0];
            assign src[1] = blank_sel_ff[g][7:4];
            assign src[2] = blank_sel_ff[g][11:8];
            for (genvar m = 0; m < 3; m++)
            begin : g_mask
                always_comb
                begin
                    picked[m] = 1'b0;
                    if (src[m] <= CEC_SRC_PWM_LAST)
                    begin
                        picked[m] = blank_src[src[m]];
                    end
                    else if (src[m] >= CEC_SRC_TRIG18)
                    begin
                        picked[m] = blank_src[4'(src[m] - CEC_SRC_TRIG18 + 4'h6)];
                    end
                end
            end

            // Registered outputs: pin, event pulse, routing and masks
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    compare_output_pin[g] <= 1'b0;
                    event_pulse[g] <= 1'b0;
                    route_ff[g] <= '0;
                    blank_mask_ff[3*g +: 3] <= 3'h0;
                    unit_active[g] <= 1'b0;
                end
                else
                begin
                    unit_active[g] <= ctrl_ff[g][CEC_B_ENABLE]
                        && !(idle_halt_select_ff && idle_mode);
                    compare_output_pin[g] <= running[g] && ctrl_ff[g][CEC_B_PIN_OE]
                        && !amp && adj[g];
                    event_pulse[g] <= fire[g];
                    route_ff[g].unit_enable <= running[g];
                    route_ff[g].amplifier_mode_select <= amp;
                    route_ff[g].positive_input_ref_select <= ctrl_ff[g][CEC_B_REF];
                    route_ff[g].neg_sel <= neg;
                    // Units 1-3: codes 10, 11 absent; second pin absent in amplifier
                    route_ff[g].neg_ground <= HAS_AMP && (neg[1]
                        || (amp && neg == CEC_NEG_SECOND));
                    blank_mask_ff[3*g +: 3] <= picked;
                end
            end
        end
    endgenerate

    // Assertions
    a_flag_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff[1][CEC_B_EVENT] |-> !fire[1])
        else $error("event fired while flag set");
    a_edge_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl_ff[1][7:6] == CEC_EDGE_OFF) |-> ##1 !event_pulse[1])
        else $error("event with edge select off");
    a_rise_fire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (running[1] && !ctrl_ff[1][CEC_B_EVENT] && ctrl_ff[1][7:6] == CEC_EDGE_RISE
        && !adj_prev_ff[1] && adj[1]) |=> event_pulse[1] && ctrl_ff[1][CEC_B_EVENT])
        else $error("rising edge missed");
    a_fall_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fire[1] && ctrl_ff[1][7:6] == CEC_EDGE_FALL) |-> $past(adj[1]) && !adj[1])
        else $error("fall event without fall");
    a_any_change: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fire[1] && ctrl_ff[1][7:6] == CEC_EDGE_ANY) |-> adj[1] != $past(adj[1]))
        else $error("any change event without change");
    a_amp_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_ff[0][CEC_B_AMP] |=> compare_output_pin[0] == 1'b0)
        else $error("pin driven in amplifier mode");
    a_mirror_res: assert property (@(posedge clk_sys) disable iff (!rst_n)
        status_word[3:0] == {ctrl_ff[3][8], ctrl_ff[2][8], ctrl_ff[1][8], ctrl_ff[0][8]})
        else $error("result mirror mismatch");
    a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl_ff[3] & ~CEC_CTRL4_WMASK & 16'hFEFF) == 16'h0000)
        else $error("unimplemented bit set");
    a_idle_halt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (idle_halt_select_ff && idle_mode) |=> !unit_active[2])
        else $error("unit ran while halted in idle");
    a_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl_ff[1][CEC_B_EVENT] && !(wr_lo && idx == CEC_IDX_CTRL2))
        |=> ctrl_ff[1][CEC_B_EVENT])
        else $error("event flag lost without clear");

    // Stages two and three agree on a level not yet accepted
    sequence s_agree;
        sync2_ff[1] == sync3_ff[1] && sync3_ff[1] != stable_ff[1];
    endsequence
    a_sync_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_agree |=> stable_ff[1] == $past(sync3_ff[1]))
        else $error("agreed level not taken");
endmodule : cec_top

// ---- testbench/cec_analog_model.sv ----
/*
 * Behavioural far side: four comparator cores and the blanking sources.
 * Assumes the bench sets analog levels and source levels by clocked writes.
 */
`timescale 1ns/1ns
module cec_analog_model
    import cec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] pos_lvl,
    input wire logic [31:0] neg_lvl,
    input wire logic [9:0] src_lvl,
    output logic [3:0] raw_result,
    output cec_blank_src_t blank_src
);
    // Cores compare 8-bit levels; the output moves off the system edge
    always_ff @(negedge clk_sys)
    begin
        for (int u = 0; u < 4; u++)
        begin
            raw_result[u] <= pos_lvl[8*u +: 8] > neg_lvl[8*u +: 8];
        end
    end
    // Blanking sources follow the requested pattern
    always_ff @(negedge clk_sys)
    begin
        blank_src <= cec_blank_src_t'(src_lvl);
    end
endmodule : cec_analog_model

// ---- testbench/comparator_event_control_tb_top.sv ----
/*
 * Self-checking bench for the comparator event control block.
 * Assumes the package, the design top and the analog model are compiled first.
 */
`timescale 1ns/1ns
module comparator_event_control_tb_top
    import cec_pkg::*;
;
    logic clk_sys, rst_n, avs_read, avs_write, idle_mode, avs_waitrequest, avs_response_err;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, pos_lvl, neg_lvl;
    logic [3:0] avs_byteenable, raw_result, compare_output_pin, event_pulse, unit_active;
    logic [9:0] src_lvl;
    logic [11:0] blank_mask_ff;
    cec_blank_src_t blank_src;
    cec_route_t [3:0] route_ff;
    int fails, checks;
    int evt_cnt [4];
    logic [15:0] rd;
    logic rerr;

    cec_top #(.UNITS(4)) i_cec_top (.clk_sys(clk_sys), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response_err(avs_response_err), .idle_mode(idle_mode),
        .raw_result(raw_result), .blank_src(blank_src),
        .compare_output_pin(compare_output_pin), .event_pulse(event_pulse),
        .route_ff(route_ff), .unit_active(unit_active), .blank_mask_ff(blank_mask_ff));
    cec_analog_model i_cec_analog_model (.clk_sys(clk_sys), .pos_lvl(pos_lvl),
        .neg_lvl(neg_lvl), .src_lvl(src_lvl), .raw_result(raw_result), .blank_src(blank_src));

    // Free-running 10 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Event pulse counters, one per unit
    always @(posedge clk_sys)
    begin
        for (int u = 0; u < 4; u++)
            if (event_pulse[u] === 1'b1) evt_cnt[u] <= evt_cnt[u] + 1;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // Register value compare
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg
    // Port level compare
    task automatic chk_sig(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_sig
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_cyc
    // Hold the request until waitrequest is seen low at an edge
    task automatic bus_wait();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fails++;
    endtask : bus_wait
    task automatic bus_write(input logic [3:0] idx, input logic [15:0] val, input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, val};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        bus_wait();
        avs_write <= 1'b0;
    endtask : bus_write
    // Read data is registered and stands until the next read
    task automatic bus_read(input logic [3:0] idx, output logic [15:0] data, output logic err);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        bus_wait();
        data = avs_readdata[15:0];
        err = avs_response_err;
        avs_read <= 1'b0;
    endtask : bus_read
    task automatic rd_chk(input logic [3:0] idx, input logic [15:0] exp);
        bus_read(idx, rd, rerr);
        chk_reg(rd, exp);
    endtask : rd_chk
    task automatic set_lvl(input int u, input logic [7:0] p, input logic [7:0] n);
        @(posedge clk_sys);
        pos_lvl[8*u +: 8] <= p;
        neg_lvl[8*u +: 8] <= n;
    endtask : set_lvl

    // Reset values, write masks, refused writes and an unmapped read
    task automatic t_regs();
        for (int i = 0; i < 9; i++) rd_chk(4'(i), CEC_RESET_VALUE);
        bus_read(4'h9, rd, rerr);
        chk_sig({11'h000, rerr}, 12'h001);
        bus_write(CEC_IDX_CTRL1, 16'hDFFF, 4'hF);
        rd_chk(CEC_IDX_CTRL1, 16'hC4D3);
        bus_write(CEC_IDX_CTRL4, 16'hDFFF, 4'hF);
        rd_chk(CEC_IDX_CTRL4, 16'hC0D3);
        bus_write(CEC_IDX_BLANK1, 16'hFFFF, 4'hF);
        rd_chk(CEC_IDX_BLANK1, 16'h0FFF);
        bus_write(CEC_IDX_STATUS, 16'hFFFF, 4'hF);
        rd_chk(CEC_IDX_STATUS, 16'h8000);
        bus_write(CEC_IDX_CTRL2, 16'h8000, 4'hC);
        rd_chk(CEC_IDX_CTRL2, 16'h0000);
        for (int i = 0; i < 6; i++) bus_write(4'(i), 16'h0000, 4'hF);
        bus_write(CEC_IDX_BLANK1, 16'h0000, 4'hF);
    endtask : t_regs
    // Enable, pin enable, inversion and the status mirror on unit 1
    task automatic t_result();
        set_lvl(0, 8'hC8, 8'h64);
        bus_write(CEC_IDX_CTRL1, 16'hC000, 4'hF);
        wait_cyc(10);
        rd_chk(CEC_IDX_CTRL1, 16'hC100);
        rd_chk(CEC_IDX_STATUS, 16'h0001);
        chk_sig({8'h00, compare_output_pin}, 12'h001);
        chk_sig({8'h00, unit_active}, 12'h001);
        bus_write(CEC_IDX_CTRL1, 16'hE000, 4'hF);
        wait_cyc(10);
        rd_chk(CEC_IDX_CTRL1, 16'hE000);
        chk_sig({8'h00, compare_output_pin}, 12'h000);
        set_lvl(0, 8'h32, 8'h64);
        wait_cyc(10);
        rd_chk(CEC_IDX_STATUS, 16'h0001);
        chk_sig({8'h00, compare_output_pin}, 12'h001);
        bus_write(CEC_IDX_CTRL1, 16'hA000, 4'hF);
        wait_cyc(4);
        chk_sig({8'h00, compare_output_pin}, 12'h000);
        bus_write(CEC_IDX_CTRL1, 16'h6000, 4'hF);
        wait_cyc(4);
        chk_sig({8'h00, unit_active}, 12'h000);
        bus_write(CEC_IDX_CTRL1, 16'h0000, 4'hF);
        set_lvl(0, 8'h00, 8'h00);
    endtask : t_result
    // One edge code on unit 2: count events for a raw rise, then a raw fall
    task automatic t_event(input logic [1:0] code, input logic inv);
        logic [15:0] base;
        int c0;
        logic rise_x, fall_x;
        base = {2'b10, inv, 13'h0000};
        rise_x = inv ? code[1] : code[0];
        fall_x = inv ? code[0] : code[1];
        set_lvl(1, 8'h10, 8'h80);
        bus_write(CEC_IDX_CTRL2, base, 4'hF);
        wait_cyc(10);
        bus_write(CEC_IDX_CTRL2, base | {8'h00, code, 6'h00}, 4'hF);
        c0 = evt_cnt[1];
        set_lvl(1, 8'h90, 8'h80);
        wait_cyc(12);
        chk_sig(12'(evt_cnt[1] - c0), {11'h000, rise_x});
        bus_read(CEC_IDX_CTRL2, rd, rerr);
        chk_reg(rd & 16'h0200, {6'h00, rise_x, 9'h000});
        bus_read(CEC_IDX_STATUS, rd, rerr);
        chk_reg(rd & 16'h0200, {6'h00, rise_x, 9'h000});
        bus_write(CEC_IDX_CTRL2, base | {8'h00, code, 6'h00}, 4'hF);
        c0 = evt_cnt[1];
        set_lvl(1, 8'h10, 8'h80);
        wait_cyc(12);
        chk_sig(12'(evt_cnt[1] - c0), {11'h000, fall_x});
        bus_write(CEC_IDX_CTRL2, 16'h0000, 4'hF);
    endtask : t_event
    // A set flag blocks further events until it is cleared
    task automatic t_block();
        int c0;
        set_lvl(1, 8'h10, 8'h80);
        bus_write(CEC_IDX_CTRL2, 16'h80C0, 4'hF);
        wait_cyc(10);
        c0 = evt_cnt[1];
        set_lvl(1, 8'h90, 8'h80);
        wait_cyc(12);
        set_lvl(1, 8'h10, 8'h80);
        wait_cyc(12);
        chk_sig(12'(evt_cnt[1] - c0), 12'h001);
        bus_write(CEC_IDX_CTRL2, 16'h80C0, 4'hF);
        set_lvl(1, 8'h90, 8'h80);
        wait_cyc(12);
        chk_sig(12'(evt_cnt[1] - c0), 12'h002);
        bus_write(CEC_IDX_CTRL2, 16'h0000, 4'hF);
        set_lvl(1, 8'h00, 8'h00);
    endtask : t_block
    // Input routing for every select code, and amplifier mode
    task automatic t_route();
        for (int c = 0; c < 4; c++)
        begin
            bus_write(CEC_IDX_CTRL4, 16'h8010 | 16'(c), 4'hF);
            bus_write(CEC_IDX_CTRL1, 16'h8000 | 16'(c), 4'hF);
            wait_cyc(3);
            chk_sig({6'h00, route_ff[3]}, {6'h00, 3'b101, 2'(c), 1'b0});
            chk_sig({6'h00, route_ff[0]}, {6'h00, 3'b100, 2'(c), c[1]});
        end
        set_lvl(0, 8'hC8, 8'h64);
        bus_write(CEC_IDX_CTRL1, 16'hC401, 4'hF);
        wait_cyc(10);
        chk_sig({6'h00, route_ff[0]}, 12'h033);
        chk_sig({8'h00, compare_output_pin}, 12'h000);
        bus_write(CEC_IDX_CTRL1, 16'h0000, 4'hF);
        bus_write(CEC_IDX_CTRL4, 16'h0000, 4'hF);
        set_lvl(0, 8'h00, 8'h00);
    endtask : t_route
    // Idle halt select against the idle level
    task automatic t_idle();
        bus_write(CEC_IDX_CTRL3, 16'h8000, 4'hF);
        idle_mode <= 1'b1;
        bus_write(CEC_IDX_STATUS, 16'h8000, 4'hF);
        wait_cyc(3);
        chk_sig({8'h00, unit_active}, 12'h000);
        bus_write(CEC_IDX_STATUS, 16'h0000, 4'hF);
        wait_cyc(3);
        chk_sig({8'h00, unit_active}, 12'h004);
        idle_mode <= 1'b0;
        bus_write(CEC_IDX_STATUS, 16'h8000, 4'hF);
        wait_cyc(3);
        chk_sig({8'h00, unit_active}, 12'h004);
        bus_write(CEC_IDX_STATUS, 16'h0000, 4'hF);
        bus_write(CEC_IDX_CTRL3, 16'h0000, 4'hF);
    endtask : t_idle
    // Every blanking source code, then the field positions
    task automatic t_blank();
        int s;
        for (int c = 0; c < 16; c++)
        begin
            s = (c < 6) ? c : ((c > 11) ? c - 6 : -1);
            src_lvl <= (s < 0) ? 10'h3FF : 10'(1 << s);
            bus_write(CEC_IDX_BLANK1, {4'h0, 4'(c), 4'(c), 4'(c)}, 4'hF);
            wait_cyc(4);
            chk_sig(blank_mask_ff, {{9{s <= 0}}, (s < 0) ? 3'h0 : 3'h7});
        end
        src_lvl <= 10'h002;
        bus_write(CEC_IDX_BLANK4, 16'h0210, 4'hF);
        wait_cyc(4);
        chk_sig(blank_mask_ff, 12'h400);
    endtask : t_blank

    // Main sequence
    initial
    begin
        {rst_n, avs_read, avs_write, idle_mode} = 4'h0;
        {avs_address, avs_writedata, pos_lvl, neg_lvl, src_lvl} = '0;
        avs_byteenable = 4'hF;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        $display("regs done fails=%0d", fails);
        t_result();
        $display("result done fails=%0d", fails);
        for (int k = 0; k < 4; k++) t_event(2'(k), 1'b0);
        t_event(CEC_EDGE_RISE, 1'b1);
        t_event(CEC_EDGE_FALL, 1'b1);
        $display("events done fails=%0d", fails);
        t_block();
        $display("block done fails=%0d", fails);
        t_route();
        $display("route done fails=%0d", fails);
        t_idle();
        $display("idle done fails=%0d", fails);
        t_blank();
        $display("blank done fails=%0d", fails);
        close_out();
    end
    // Watchdog well beyond the expected several hundred cycles
    initial
    begin
        #(100 * 20000);
        fails++;
        close_out();
    end
endmodule : comparator_event_control_tb_top
